// *** hw/frp_top.sv ***
// Shared buffer read pacing and write/read error flags of the video path
// Assumes a register port with read data one cycle after the read strobe,
// and a memory request port that may hold off with mem_req_ready low
//
// The register addresses and the strobed register port are this design's own decisions.
`include "frp_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module frp_top #(
  parameter int NREQ = `FRP_NREQ,
  parameter int SPC_W = `FRP_SPC_W,
  parameter int GAP_W = `FRP_GAP_W
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [NREQ-1:0] line_valid,
  input wire frp_pkg::frp_line_t [NREQ-1:0] line_desc,
  output logic [NREQ-1:0] line_ready,
  input wire logic [NREQ-1:0] buf_space,
  output logic mem_req_valid,
  output frp_pkg::frp_mreq_t mem_req,
  input wire logic mem_req_ready,
  input wire logic [`FRP_OVF_W-1:0] wbuf_overflow_evt,
  input wire logic fault_pixel_miss_evt,
  input wire logic dark_read_fail_evt,
  output logic irq
);
  logic [SPC_W-1:0] spacing_prv;
  logic [SPC_W-1:0] spacing_rsz;
  logic [SPC_W-1:0] spacing_hst;
  logic [`FRP_OVF_W-1:0] peripheral_control_reg;
  logic fault_pixel_read_error;
  logic fpc_enable;
  logic darkframe_read_failure;
  logic dark_enable;
  logic [`FRP_ERR_W-1:0] irq_mask;
  logic [NREQ-1:0] read_enable;
  logic [`FRP_ERR_W-1:0] err_flags;
  logic [NREQ-1:0] chunk_valid;
  logic [31:0] chunk_addr [NREQ];
  logic [8:0] chunk_len [NREQ];
  logic [NREQ-1:0] pace_ok;
  logic [NREQ-1:0] eligible;
  logic [NREQ-1:0] grant;
  logic [NREQ-1:0] next_grant;
  logic [GAP_W-1:0] gap [NREQ];
  logic [1:0] rr_last;
  logic out_free;
  logic [15:0] issue_count;
  logic [31:0] next_rdata;

  // Write decode, shared by all register processes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wr_spacing;
  logic wr_periph;
  logic wr_capture;
  logic wr_preview;
  logic wr_istat;
  logic wr_imask;
  logic wr_ctrl;

  assign wr_spacing = reg_wr && hit(reg_addr, `FRP_OFS_SPACING);
  assign wr_periph = reg_wr && hit(reg_addr, `FRP_OFS_PERIPH);
  assign wr_capture = reg_wr && hit(reg_addr, `FRP_OFS_CAPTURE);
  assign wr_preview = reg_wr && hit(reg_addr, `FRP_OFS_PREVIEW);
  assign wr_istat = reg_wr && hit(reg_addr, `FRP_OFS_IRQ_STAT);
  assign wr_imask = reg_wr && hit(reg_addr, `FRP_OFS_IRQ_MASK);
  assign wr_ctrl = reg_wr && hit(reg_addr, `FRP_OFS_CTRL);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      spacing_prv <= SPC_W'(`FRP_SPC_RESET);
      spacing_rsz <= SPC_W'(`FRP_SPC_RESET);
      spacing_hst <= SPC_W'(`FRP_SPC_RESET);
    end else if (wr_spacing) begin
      spacing_prv <= reg_wdata[`FRP_SPC_PRV_LSB +: SPC_W];
      spacing_rsz <= reg_wdata[`FRP_SPC_RSZ_LSB +: SPC_W];
      spacing_hst <= reg_wdata[`FRP_SPC_HST_LSB +: SPC_W];
    end
  end

  // Enables for the three readers and the two error sources
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      read_enable <= NREQ'(`FRP_CTRL_RESET);
    end else if (wr_ctrl) begin
      read_enable <= reg_wdata[NREQ-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fpc_enable <= 1'b0;
    end else if (wr_capture) begin
      fpc_enable <= reg_wdata[1];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dark_enable <= 1'b0;
    end else if (wr_preview) begin
      dark_enable <= reg_wdata[1];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_mask <= '0;
    end else if (wr_imask) begin
      irq_mask <= reg_wdata[`FRP_ERR_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      peripheral_control_reg <= '0;
    end else begin
      for (int i = 0; i < `FRP_OVF_W; i++) begin
        if (wbuf_overflow_evt[i]) begin
          peripheral_control_reg[i] <= 1'b1;
        end else if ((wr_periph && reg_wdata[i]) ||
                     (wr_istat && reg_wdata[i])) begin
          peripheral_control_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Set beats clear, so an event in the clearing cycle is never lost
  function automatic logic sticky(
    input logic cur,
    input logic ev,
    input logic clr
  );
    if (ev) begin
      sticky = 1'b1;
    end else if (clr) begin
      sticky = 1'b0;
    end else begin
      sticky = cur;
    end
  endfunction

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fault_pixel_read_error <= 1'b0;
    end else begin
      fault_pixel_read_error <= sticky(fault_pixel_read_error,
        fpc_enable && fault_pixel_miss_evt,
        (wr_capture && reg_wdata[0]) ||
        (wr_istat && reg_wdata[`FRP_ERR_FP_BIT]));
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      darkframe_read_failure <= 1'b0;
    end else begin
      darkframe_read_failure <= sticky(darkframe_read_failure,
        dark_enable && dark_read_fail_evt,
        (wr_preview && reg_wdata[0]) ||
        (wr_istat && reg_wdata[`FRP_ERR_DARK_BIT]));
    end
  end

  assign err_flags = {darkframe_read_failure, fault_pixel_read_error,
                      peripheral_control_reg};
  assign irq = |(err_flags & irq_mask);

  // Widens a spacing field to the gap counter; the cast cuts on purpose,
  // the largest product still fits the default counter width
  function automatic logic [GAP_W-1:0] scale_gap(
    input logic [SPC_W-1:0] f,
    input int sh
  );
    scale_gap = GAP_W'(32'(f) << sh);
  endfunction

  assign gap[0] = scale_gap(spacing_prv, 0);
  assign gap[1] = scale_gap(spacing_rsz, `FRP_RSZ_SHIFT);
  assign gap[2] = scale_gap(spacing_hst, 0);

  genvar g;
  generate
    for (g = 0; g < NREQ; g++) begin : g_req
      frp_splitter u_split (
        .clock(clock),
        .sys_rst(sys_rst),
        .line_valid(line_valid[g]),
        .line_desc(line_desc[g]),
        .line_ready(line_ready[g]),
        .chunk_valid(chunk_valid[g]),
        .chunk_addr(chunk_addr[g]),
        .chunk_len(chunk_len[g]),
        .issue(grant[g])
      );
      frp_pacer #(.GAP_W(GAP_W)) u_pace (
        .clock(clock),
        .sys_rst(sys_rst),
        .gap(gap[g]),
        .issue(grant[g]),
        .pace_ok(pace_ok[g])
      );
    end
  endgenerate

  assign eligible = chunk_valid & pace_ok & buf_space & read_enable;

  // The output stage refills in the cycle it is drained, so an
  // unpaced reader keeps one request per cycle
  // Full rate when unpaced
  assign out_free = !mem_req_valid || mem_req_ready;

  // Round robin so a busy unpaced reader cannot starve the others
  always_comb begin
    logic [1:0] idx;
    idx = 2'd0;
    next_grant = '0;
    if (out_free) begin
      for (int k = NREQ; k >= 1; k--) begin
        idx = 2'((32'(rr_last) + k) % NREQ);
        if (eligible[idx]) begin
          next_grant = '0;
          next_grant[idx] = 1'b1;
        end
      end
    end
  end

  assign grant = next_grant;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rr_last <= 2'd2;
    end else begin
      for (int k = 0; k < NREQ; k++) begin
        if (grant[k]) begin
          rr_last <= 2'(k);
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mem_req_valid <= 1'b0;
      mem_req <= '0;
    end else if (out_free) begin
      mem_req_valid <= |grant;
      for (int k = 0; k < NREQ; k++) begin
        if (grant[k]) begin
          mem_req.addr <= chunk_addr[k];
          mem_req.len <= chunk_len[k];
          mem_req.src <= 2'(k);
        end
      end
    end
  end

  // Wraps freely; software reads it as a progress indicator
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      issue_count <= 16'h0000;
    end else if (|grant) begin
      issue_count <= issue_count + 16'h0001;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (reg_addr)
      `FRP_OFS_SPACING: begin
        next_rdata[`FRP_SPC_PRV_LSB +: SPC_W] = spacing_prv;
        next_rdata[`FRP_SPC_RSZ_LSB +: SPC_W] = spacing_rsz;
        next_rdata[`FRP_SPC_HST_LSB +: SPC_W] = spacing_hst;
      end
      `FRP_OFS_PERIPH: begin
        next_rdata[`FRP_OVF_W-1:0] = peripheral_control_reg;
      end
      `FRP_OFS_CAPTURE: begin
        next_rdata[1:0] = {fpc_enable, fault_pixel_read_error};
      end
      `FRP_OFS_PREVIEW: begin
        next_rdata[1:0] = {dark_enable, darkframe_read_failure};
      end
      `FRP_OFS_IRQ_STAT: begin
        next_rdata[`FRP_ERR_W-1:0] = err_flags;
      end
      `FRP_OFS_IRQ_MASK: begin
        next_rdata[`FRP_ERR_W-1:0] = irq_mask;
      end
      `FRP_OFS_CTRL: begin
        next_rdata[NREQ-1:0] = read_enable;
      end
      `FRP_OFS_STATE: begin
        next_rdata[NREQ-1:0] = chunk_valid;
        next_rdata[4+NREQ-1:4] = pace_ok;
        next_rdata[8] = mem_req_valid;
        next_rdata[31:16] = issue_count;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// *** include/frp_regs.svh ***
// Register offsets, field positions, reset values and timing counts
// Assumes byte addresses on an 8-bit register port with 32-bit data
`ifndef FRP_REGS_SVH
`define FRP_REGS_SVH

`define FRP_OFS_SPACING 8'h00
`define FRP_OFS_PERIPH 8'h04
`define FRP_OFS_CAPTURE 8'h08
`define FRP_OFS_PREVIEW 8'h0C
`define FRP_OFS_IRQ_STAT 8'h10
`define FRP_OFS_IRQ_MASK 8'h14
`define FRP_OFS_CTRL 8'h18
`define FRP_OFS_STATE 8'h1C

`define FRP_SPC_W 10
`define FRP_SPC_PRV_LSB 0
`define FRP_SPC_RSZ_LSB 10
`define FRP_SPC_HST_LSB 20
`define FRP_SPC_RESET 32'h0000_0000
`define FRP_RSZ_SHIFT 5
`define FRP_GAP_W 15

`define FRP_OVF_W 8
`define FRP_ERR_W 10
`define FRP_ERR_FP_BIT 8
`define FRP_ERR_DARK_BIT 9
`define FRP_CTRL_RESET 32'h0000_0007

`define FRP_BOUNDARY 9'h100
`define FRP_NREQ 3
`endif

// *** include/frp_pkg.sv ***
// Types shared by the frame read pacing block
// Assumes frp_regs.svh is on the include path
package frp_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] len;
  } frp_line_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [8:0] len;
    logic [1:0] src;
  } frp_mreq_t;

  typedef enum logic [1:0] {
    FRP_SRC_PREVIEW,
    FRP_SRC_RESIZER,
    FRP_SRC_HISTOGRAM
  } frp_src_t;

  // Bytes left before the next 256-byte boundary, capped by the line rest
  function automatic logic [8:0] frp_chunk_len(input logic [31:0] addr,
                                               input logic [15:0] rest);
    logic [8:0] to_edge;
    to_edge = 9'h100 - {1'b0, addr[7:0]};
    if (rest < {7'h00, to_edge}) begin
      frp_chunk_len = rest[8:0];
    end else begin
      frp_chunk_len = to_edge;
    end
  endfunction
endpackage

// *** hw/frp_pacer.sv ***
// Per-requester minimum spacing counter between issued read requests
// Assumes issue is a one-cycle pulse in the cycle a request is granted
`timescale 1ns/10ps
`default_nettype none
module frp_pacer #(
  parameter int GAP_W = 15
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [GAP_W-1:0] gap,
  input wire logic issue,
  output logic pace_ok
);
  logic [GAP_W-1:0] count;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count <= '1;
    end else if (issue) begin
      count <= {{(GAP_W-1){1'b0}}, 1'b1};
    end else if (count != '1) begin
      count <= count + 1'b1;
    end
  end

  assign pace_ok = (count >= gap);
endmodule
`default_nettype wire

// *** hw/frp_splitter.sv ***
// Splits one frame line into requests that never cross a 256-byte edge
// Assumes the line descriptor holds steady while line_valid is high
`timescale 1ns/10ps
`default_nettype none
module frp_splitter (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic line_valid,
  input wire frp_pkg::frp_line_t line_desc,
  output logic line_ready,
  output logic chunk_valid,
  output logic [31:0] chunk_addr,
  output logic [8:0] chunk_len,
  input wire logic issue
);
  typedef enum logic {FRP_SPL_IDLE, FRP_SPL_BUSY} frp_spl_t;
  frp_spl_t state;
  logic [31:0] addr;
  logic [15:0] rest;

  assign chunk_len = frp_pkg::frp_chunk_len(addr, rest);
  assign chunk_addr = addr;
  assign chunk_valid = (state == FRP_SPL_BUSY);
  assign line_ready = (state == FRP_SPL_IDLE);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= FRP_SPL_IDLE;
      addr <= 32'h0000_0000;
      rest <= 16'h0000;
    end else begin
      unique case (state)
        FRP_SPL_IDLE: begin
          if (line_valid && line_desc.len != 16'h0000) begin
            addr <= line_desc.addr;
            rest <= line_desc.len;
            state <= FRP_SPL_BUSY;
          end
        end
        FRP_SPL_BUSY: begin
          if (issue) begin
            addr <= addr + {23'h000000, chunk_len};
            rest <= rest - {7'h00, chunk_len};
            if (rest == {7'h00, chunk_len}) begin
              state <= FRP_SPL_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** bench/frp_mem_model.sv ***
// Memory side model that takes read requests on the shared clock
// Assumes slow is driven by the bench off the sampling edge
`timescale 1ns/10ps
`default_nettype none
module frp_mem_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic slow,
  output logic mem_req_ready
);
  logic [1:0] tick;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tick <= 2'h0;
    end else begin
      tick <= tick + 2'h1;
    end
  end
  // Memory side serves every cycle unless slow is set
  // Slow mode takes one cycle in four so held requests get exercised
  assign mem_req_ready = !slow || (tick == 2'h3);
endmodule
`default_nettype wire

// *** bench/frp_top_sva.sv ***
// Port checker for frp_top: request shape, pacing and flags
// Assumes one clock and a synchronous active high reset
`timescale 1ns/10ps
`default_nettype none
module frp_top_sva #(
  parameter int NREQ = 3
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [NREQ-1:0] buf_space,
  input wire logic mem_req_valid,
  input wire frp_pkg::frp_mreq_t mem_req,
  input wire logic mem_req_ready,
  input wire logic [7:0] wbuf_overflow_evt,
  input wire logic fault_pixel_miss_evt,
  input wire logic dark_read_fail_evt,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic pv, pr, fresh;
  logic [NREQ-1:0] pb;
  logic [29:0] spc;
  logic [15:0] need;
  logic [15:0] cnt [3];
  // A new request is one not merely held over from the cycle before
  assign fresh = mem_req_valid && (!pv || pr);
  assign need = mem_req.src == 2'h1 ? {1'b0, spc[19:10], 5'h00} :
    {6'h00, mem_req.src == 2'h2 ? spc[29:20] : spc[9:0]};
  always_ff @(posedge clock) begin
    pv <= !sys_rst && mem_req_valid;
    pr <= mem_req_ready;
    pb <= buf_space;
    if (sys_rst) begin
      spc <= 30'h0;
    end else if (reg_wr && reg_addr == 8'h00) begin
      spc <= reg_wdata[29:0];
    end
  end
  always_ff @(posedge clock) begin
    for (int k = 0; k < 3; k++) begin
      if (sys_rst) begin
        cnt[k] <= 16'hFFFF;
      end else if (fresh && mem_req.src == 2'(k)) begin
        cnt[k] <= 16'h0001;
      end else if (cnt[k] != 16'hFFFF) begin
        cnt[k] <= cnt[k] + 16'h0001;
      end
    end
  end
  a_req_hold: assert property (
    mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req))
    else $error("request changed before accept");
  a_len_range: assert property (
    mem_req_valid |-> mem_req.len != 9'h0 && mem_req.len <= 9'h100)
    else $error("request length out of range");
  a_no_cross: assert property (
    mem_req_valid |->
    {2'h0, mem_req.addr[7:0]} + {1'b0, mem_req.len} <= 10'h100)
    else $error("request crosses 256 byte edge");
  a_space_gate: assert property (fresh |-> pb[mem_req.src])
    else $error("request issued without buffer room");
  a_gap_min: assert property (
    fresh |-> cnt[mem_req.src] >= need)
    else $error("requests closer than spacing");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_irq_cause: assert property ($rose(irq) |->
    $past(|wbuf_overflow_evt || fault_pixel_miss_evt || dark_read_fail_evt ||
    reg_wr)) else $error("interrupt without cause");
  a_irq_sticky: assert property (irq && !reg_wr |=> irq)
    else $error("interrupt dropped without write");
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Testbench for frp_top: line splitting, pacing, error flags, interrupt
// Assumes frp_mem_model on the memory side and the checker bound below
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [2:0] line_valid = 3'h0;
  frp_pkg::frp_line_t [2:0] line_desc = '0;
  logic [2:0] line_ready;
  logic [2:0] buf_space = 3'h7;
  logic mem_req_valid, mem_req_ready, irq;
  frp_pkg::frp_mreq_t mem_req;
  logic [7:0] wbuf_overflow_evt = 8'h00;
  logic fault_pixel_miss_evt = 1'b0;
  logic dark_read_fail_evt = 1'b0;
  logic slow = 1'b0;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  frp_pkg::frp_mreq_t got [$];
  frp_pkg::frp_mreq_t exp_q [$];
  int at [$];
  frp_top frp_top_i (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .line_valid, .line_desc, .line_ready, .buf_space,
    .mem_req_valid, .mem_req, .mem_req_ready, .wbuf_overflow_evt,
    .fault_pixel_miss_evt, .dark_read_fail_evt, .irq);
  frp_mem_model frp_mem_model_i (.clock, .sys_rst, .slow, .mem_req_ready);
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (mem_req_valid && mem_req_ready) begin
      got.push_back(mem_req);
      at.push_back(cyc);
    end
  end
  task automatic chk(string n, logic [63:0] e, logic [63:0] a);
    comparisons++;
    if (e !== a) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, a);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, string n);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(n, e, reg_rdata);
    @(posedge clock);
  endtask
  task automatic pulse(logic [7:0] o, logic f, logic d);
    {wbuf_overflow_evt, fault_pixel_miss_evt, dark_read_fail_evt} <= {o, f, d};
    @(posedge clock);
    {wbuf_overflow_evt, fault_pixel_miss_evt, dark_read_fail_evt} <= 10'h0;
    @(posedge clock);
  endtask
  task automatic offer(int s, logic [31:0] a, logic [15:0] n);
    frp_pkg::frp_mreq_t e;
    int c;
    line_desc[s] <= {a, n};
    line_valid[s] <= 1'b1;
    @(posedge clock);
    while (!line_ready[s]) @(posedge clock);
    line_valid[s] <= 1'b0;
    @(posedge clock);
    while (n != 16'h0) begin
      c = 256 - a[7:0];
      if (n < c) c = n;
      e = {a, 9'(c), 2'(s)};
      exp_q.push_back(e);
      a += 32'(c);
      n -= 16'(c);
    end
  endtask
  task automatic wait_n(int n);
    for (int t = 0; t < 4000 && got.size() < n; t++) @(posedge clock);
  endtask
  task automatic check_all;
    int j;
    frp_pkg::frp_mreq_t seen;
    wait_n(exp_q.size());
    chk("request count", exp_q.size(), got.size());
    // Requesters interleave, so order only holds within one requester
    for (int s = 0; s < 3; s++) begin
      j = 0;
      foreach (exp_q[i]) begin
        if (exp_q[i].src == 2'(s)) begin
          while (j < got.size() && got[j].src != 2'(s)) j++;
          seen = (j < got.size()) ? got[j] : '0;
          chk("request", exp_q[i], seen);
          j++;
        end
      end
    end
    got.delete();
    exp_q.delete();
    at.delete();
  endtask
  task automatic t_burst;
    offer(0, 32'h1F0, 16'h200);
    offer(0, 32'h3F0, 16'h20);
    wait_n(3);
    chk("back to back", 2, at[2] - at[0]);
    check_all;
    slow <= 1'b1;
    offer(2, 32'h1000, 16'h180);
    check_all;
    slow <= 1'b0;
    buf_space[0] <= 1'b0;
    offer(0, 32'h40, 16'h100);
    repeat (20) @(posedge clock);
    chk("held while full", 0, got.size());
    buf_space[0] <= 1'b1;
    check_all;
    wr(8'h18, 32'h6);
    offer(0, 32'h80, 16'h40);
    repeat (10) @(posedge clock);
    chk("held while disabled", 0, got.size());
    wr(8'h18, 32'h7);
    check_all;
    rd(8'h1C, 32'h000A_0070, "state");
    $display("t_burst done");
  endtask
  task automatic t_gap;
    int g [3];
    int last [3];
    int d;
    bit in_range;
    g = '{3, 64, 1023};
    last = '{-1, -1, -1};
    wr(8'h00, 32'h3FF0_0803);
    rd(8'h00, 32'h3FF0_0803, "spacing fields");
    for (int s = 0; s < 3; s++) offer(s, 32'h0, 16'h200);
    wait_n(6);
    foreach (got[i]) begin
      d = at[i] - last[got[i].src];
      in_range = d >= g[got[i].src] && d <= g[got[i].src] + 2;
      if (last[got[i].src] >= 0) chk("gap", 1, in_range);
      last[got[i].src] = at[i];
    end
    wr(8'h00, 32'h0);
    check_all;
    $display("t_gap done");
  endtask
  task automatic t_flags;
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i, 1'b0, 1'b0);
      rd(8'h04, 32'h1 << i, "overflow flag");
      wr(8'h04, 32'h1 << i);
      rd(8'h04, 32'h0, "overflow cleared");
    end
    pulse(8'h08, 1'b1, 1'b1);
    #1 chk("masked irq", 0, irq);
    rd(8'h08, 32'h0, "fault flag disabled");
    wr(8'h14, 32'h3FF);
    #1 chk("unmasked irq", 1, irq);
    wr(8'h10, 32'h8);
    #1 chk("cleared irq", 0, irq);
    wr(8'h08, 32'h2);
    wr(8'h0C, 32'h2);
    pulse(8'h00, 1'b1, 1'b1);
    rd(8'h08, 32'h3, "fault flag");
    rd(8'h0C, 32'h3, "dark flag");
    rd(8'h10, 32'h300, "status");
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0, "unmapped");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rd(8'h10, 32'h0, "status after reset");
    rd(8'h18, 32'h7, "enables after reset");
    chk("irq after reset", 0, irq);
    $display("t_flags done");
  endtask
  task automatic finish_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rd(8'h00, 32'h0, "spacing reset");
    t_burst;
    t_gap;
    t_flags;
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    finish_test;
  end
endmodule
bind frp_top frp_top_sva #(.NREQ(NREQ)) frp_top_sva_i (.clock, .sys_rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .buf_space,
  .mem_req_valid, .mem_req, .mem_req_ready, .wbuf_overflow_evt,
  .fault_pixel_miss_evt, .dark_read_fail_evt, .irq);
`default_nettype wire
